// *** hw/interrupt_pkg.sv ***
// Shared constants, level numbers, dedicated addresses and instruction codes.
package interrupt_pkg;

   localparam int NUM_LEVELS = 32;
   localparam int LEVEL_GROUP = 4;
   localparam int NUM_SUBLEVELS = 17;
   localparam int WORD_W = 16;
   localparam int LEVEL_W = 5;
   localparam int DEVICE_ID_W = 6;

   localparam logic [4:0] LVL_POWER_FAIL = 5'h00;
   localparam logic [4:0] LVL_PARITY = 5'h01;
   localparam logic [4:0] LVL_PROTECT = 5'h02;
   localparam logic [4:0] LVL_UNIMPL = 5'h04;
   localparam logic [4:0] LVL_FP_OVERFLOW = 5'h05;
   localparam logic [4:0] LVL_IO_DATA = 5'h0C;
   localparam logic [4:0] LVL_IO_SERVICE = 5'h0D;

   // Levels whose enable latch is fixed set and ignores enable instructions.
   localparam logic [31:0] ALWAYS_ENABLED_MASK = 32'h0000_0037;
   // Levels fitted in every machine.
   localparam logic [31:0] STANDARD_LEVELS = 32'h0000_3011;

   localparam logic [15:0] DEDICATED_BASE = 16'h0020;
   localparam logic [15:0] NO_ACTIVE_RETURN_ADDR = 16'h0000;
   localparam logic [15:0] DATA_ENTRY_BASE = 16'h0080;
   localparam logic [15:0] SERVICE_ENTRY_BASE = 16'h00C0;

   localparam int CLK_PERIOD_NS = 10;
   localparam int SWITCH_TIME_NS = 2400;
   localparam int SWITCH_CYCLES = (SWITCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SWITCH_CNT_W = $clog2(SWITCH_CYCLES + 1);

   typedef enum logic [3:0] {
      SET_REQUEST_INSTR         = 4'h1,
      CLEAR_REQUEST_INSTR       = 4'h2,
      SET_ENABLE_INSTR          = 4'h3,
      CLEAR_ENABLE_INSTR        = 4'h4,
      SET_ACTIVE_INSTR          = 4'h5,
      CLEAR_ACTIVE_INSTR        = 4'h6,
      CLEAR_AND_RETURN_INSTR    = 4'h7,
      CLEAR_ACTIVE_RETURN_INSTR = 4'h8,
      EXECUTIVE_SERVICE_INSTR   = 4'h9
   } instr_op_e;

   // Return word comes first, the entry word directly after it.
   function automatic logic [15:0] return_word(input logic [4:0] lvl);
      return DEDICATED_BASE + {10'h000, lvl, 1'b0};
   endfunction

   function automatic logic [15:0] entry_word(input logic [4:0] lvl);
      return DEDICATED_BASE + {10'h000, lvl, 1'b1};
   endfunction

endpackage

// *** hw/level_state.sv ***
// Request, enable and active latches of one priority level.
`timescale 1ns/100ps
`default_nettype none
module level_state #(
   parameter bit ALWAYS_ON = 1'b0,
   parameter bit PRESENT   = 1'b1
) (
   input  wire logic clock_in,
   input  wire logic srst_in,
   input  wire logic set_req_in,
   input  wire logic clr_req_in,
   input  wire logic set_en_in,
   input  wire logic clr_en_in,
   input  wire logic set_act_in,
   input  wire logic clr_act_in,
   output logic      request_out,
   output logic      enable_out,
   output logic      active_out
);
   logic next_request;
   logic next_enable;
   logic next_active;

   // A set arriving with a clear wins so that no request is lost.
   always_comb begin
      next_request = PRESENT & (set_req_in | (request_out & ~clr_req_in)); // see R07
      next_enable = PRESENT & (ALWAYS_ON | set_en_in | (enable_out & ~clr_en_in)); // see R08
      next_active = PRESENT & (set_act_in | (active_out & ~clr_act_in)); // see R09
   end

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         request_out <= 1'b0; // see R12
         enable_out <= PRESENT & ALWAYS_ON; // see R12
         active_out <= 1'b0;
      end else begin
         request_out <= next_request;
         enable_out <= next_enable;
         active_out <= next_active;
      end
   end
endmodule
`default_nettype wire

// *** hw/sublevel_arbiter.sv ***
// Party-line sub-level arbiter: fixed priority pick, grant held until release.
`timescale 1ns/100ps
`default_nettype none
module sublevel_arbiter #(
   parameter int N = 17
) (
   input  wire logic         clock_in,
   input  wire logic         srst_in,
   input  wire logic [N-1:0] request_in,
   input  wire logic         capture_in,
   input  wire logic         release_in,
   output logic              any_request_out,
   output logic [N-1:0]      grant_out
);
   logic [N-1:0] pick;
   logic [N-1:0] next_grant;

   // Sub-level 0 has the highest priority.
   always_comb begin
      pick = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (request_in[i]) begin
            pick = '0;
            pick[i] = 1'b1; // see R05
         end
      end
      any_request_out = |request_in;
      next_grant = grant_out;
      if (release_in) begin
         next_grant = '0;
      end
      // The grant is held until the switch ends; the active latch keeps a sub-level from preempting another.
      if (capture_in) begin
         next_grant = pick; // see R05
      end
   end

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         grant_out <= '0;
      end else begin
         grant_out <= next_grant;
      end
   end
endmodule
`default_nettype wire

// *** hw/priority_interrupt_system.sv ***
// Vectored priority interrupt controller with program switching sequencer.
// Function
// R01 - Four standard levels, expandable in groups of four to 32.
// R02 - Two I/O levels each arbitrate 17 sub-levels, identifying up to 64 devices.
// R03 - Each level owns an entry word and a return word in memory.
// R04 - I/O sub-levels share the return word but have own entry words.
// R05 - Sub-levels never preempt each other; highest simultaneous sub-level wins.
// R06 - Standard levels 0, 4, C, D: power fail, unimplemented, data, service.
// R07 - Request set by line or set-request; cleared by clear-request or return.
// R08 - Enable set and cleared by instructions; only enabled requests interrupt.
// R09 - Active set on taking interrupt, cleared by clear-active or return.
// R10 - Clear-active-and-return leaves the request latch untouched.
// R11 - Set/clear active change active without switching, deferring lower levels; set-active here ignores level 0.
// R12 - Reset clears all latches except enables of levels 0, 1, 2, 4, 5.
// R13 - Interrupt needs enable, request, no higher active, instruction completed.
// R14 - Switch saves PC to return word, loads entry word, takes 2.4 us.
// R15 - Clear-and-return clears highest active level and reloads its return word.
// R16 - Data level sub-levels preempt any service level sub-level.
// R17 - Data level saves PC at 38 and enters at the device's entry word.
// R18 - After data level return, pending data request re-enters at once.
// R19 - Service level works alike with entry words C0 through FF.
// R20 - Traps abort the instruction and request; only four conditions trap.
// R21 - Unimplemented trap at level 4 keeps PC on the offending instruction.
// R22 - Unimplemented level is always enabled; enable instructions do nothing.
// R23 - Return with no level active loads PC from word 0.
// R24 - Enable instructions leave trap and power-fail levels enabled.
// R25 - Level 0 is highest priority; larger numbers are lower.
`timescale 1ns/100ps
`default_nettype none
module priority_interrupt_system #(
   parameter logic [31:0] LEVEL_PRESENT = 32'hFFFF_FFFF
) (
   input  wire logic                 clock_in,
   input  wire logic                 srst_in,
   input  wire logic [31:0]          ext_request_in,
   input  wire logic                 power_fail_autostart_in,
   input  wire logic                 unimpl_trap_in,
   input  wire logic                 parity_trap_in,
   input  wire logic                 protect_trap_in,
   input  wire logic                 fp_overflow_trap_in,
   input  wire logic [16:0]          data_sub_request_in,
   input  wire logic [16:0]          service_sub_request_in,
   input  wire logic [5:0]           device_id_in,
   input  wire logic                 instr_valid_in,
   input  wire logic [3:0]           instr_op_in,
   input  wire logic [4:0]           instr_level_in,
   input  wire logic                 instr_done_in,
   input  wire logic [15:0]          program_counter_in,
   input  wire logic [15:0]          mem_rdata_in,
   input  wire logic                 mem_ack_in,
   output logic                      mem_req_out,
   output logic                      mem_write_out,
   output logic [15:0]               mem_addr_out,
   output logic [15:0]               mem_wdata_out,
   output logic                      pc_load_out,
   output logic [15:0]               pc_value_out,
   output logic                      busy_out,
   output logic                      abort_instr_out,
   output logic                      pc_hold_out,
   output logic [16:0]               data_sub_ack_out,
   output logic [16:0]               service_sub_ack_out,
   output logic [31:0]               request_out,
   output logic [31:0]               enable_out,
   output logic [31:0]               active_out
);
   typedef enum logic [5:0] {
      ST_IDLE      = 6'b00_0001,
      ST_SAVE      = 6'b00_0010,
      ST_FETCH     = 6'b00_0100,
      ST_PAD       = 6'b00_1000,
      ST_RET_FETCH = 6'b01_0000,
      ST_RECHECK   = 6'b10_0000
   } seq_state_e;

   localparam logic [31:0] PRESENT_MASK = LEVEL_PRESENT | interrupt_pkg::STANDARD_LEVELS;

   seq_state_e state;
   seq_state_e next_state;
   logic [4:0]  level_sel;
   logic [4:0]  next_level_sel;
   logic        reenter;
   logic        next_reenter;
   logic [interrupt_pkg::SWITCH_CNT_W-1:0] cnt;
   logic [interrupt_pkg::SWITCH_CNT_W-1:0] next_cnt;
   logic        next_mem_req;
   logic        next_mem_write;
   logic [15:0] next_mem_addr;
   logic [15:0] next_mem_wdata;
   logic        next_pc_load;
   logic [15:0] next_pc_value;

   logic [31:0] set_req;
   logic [31:0] clr_req;
   logic [31:0] set_en;
   logic [31:0] clr_en;
   logic [31:0] set_act;
   logic [31:0] clr_act;
   logic [31:0] eligible;
   logic [31:0] blocked;
   logic [5:0]  take;
   logic [5:0]  highest_active;
   logic        data_any;
   logic        service_any;
   logic        start_take;
   logic        start_return;
   logic        sub_release;
   logic        instr_here;
   logic [31:0] instr_sel;
   logic [15:0] entry_addr;

   function automatic logic [31:0] level_onehot(input logic [4:0] lvl);
      return 32'h0000_0001 << lvl;
   endfunction

   // Bit 5 flags a hit; the index is the lowest set bit, which is the highest priority.
   function automatic logic [5:0] first_set(input logic [31:0] v);
      logic [5:0] r;
      r = 6'h00;
      for (int i = 31; i >= 0; i--) begin
         if (v[i]) begin
            r = {1'b1, 5'(i)}; // see R25
         end
      end
      return r;
   endfunction

   genvar g;
   generate
      for (g = 0; g < interrupt_pkg::NUM_LEVELS; g++) begin : gen_level // see R01
         level_state #(
            .ALWAYS_ON (interrupt_pkg::ALWAYS_ENABLED_MASK[g]),
            .PRESENT   (PRESENT_MASK[g])
         ) u_level (
            .clock_in    (clock_in),
            .srst_in     (srst_in),
            .set_req_in  (set_req[g]),
            .clr_req_in  (clr_req[g]),
            .set_en_in   (set_en[g]),
            .clr_en_in   (clr_en[g]),
            .set_act_in  (set_act[g]),
            .clr_act_in  (clr_act[g]),
            .request_out (request_out[g]),
            .enable_out  (enable_out[g]),
            .active_out  (active_out[g])
         );
      end
   endgenerate

   sublevel_arbiter #(
      .N (interrupt_pkg::NUM_SUBLEVELS)
   ) u_data_arb (
      .clock_in        (clock_in),
      .srst_in         (srst_in),
      .request_in      (data_sub_request_in),
      .capture_in      (start_take && take[4:0] == interrupt_pkg::LVL_IO_DATA),
      .release_in      (sub_release),
      .any_request_out (data_any),
      .grant_out       (data_sub_ack_out)
   );

   sublevel_arbiter #(
      .N (interrupt_pkg::NUM_SUBLEVELS)
   ) u_service_arb (
      .clock_in        (clock_in),
      .srst_in         (srst_in),
      .request_in      (service_sub_request_in),
      .capture_in      (start_take && take[4:0] == interrupt_pkg::LVL_IO_SERVICE),
      .release_in      (sub_release),
      .any_request_out (service_any),
      .grant_out       (service_sub_ack_out)
   );
   always_comb begin
      blocked = 32'h0000_0000;
      for (int i = 0; i < 32; i++) begin
         blocked[i] = |(active_out & ((32'h0000_0002 << i) - 32'h0000_0001)); // see R13 R16
      end
      eligible = request_out & enable_out & ~blocked; // see R08 R13
      take = first_set(eligible);
      highest_active = first_set(active_out); // see R15
      instr_here = instr_valid_in && state == ST_IDLE;
      instr_sel = level_onehot(instr_level_in);
      start_return = instr_here && (instr_op_in == interrupt_pkg::CLEAR_AND_RETURN_INSTR ||
                     instr_op_in == interrupt_pkg::CLEAR_ACTIVE_RETURN_INSTR);
      start_take = take[5] && !start_return &&
                   ((state == ST_IDLE && instr_done_in) || state == ST_RECHECK); // see R13 R18
      abort_instr_out = unimpl_trap_in | parity_trap_in | protect_trap_in |
                        fp_overflow_trap_in; // see R20
      // The CPU must keep its PC on an unimplemented-instruction trap or an executive service instruction.
      pc_hold_out = unimpl_trap_in |
                    (instr_here && instr_op_in == interrupt_pkg::EXECUTIVE_SERVICE_INSTR); // see R21
   end
   always_comb begin
      set_req = ext_request_in;
      set_req[interrupt_pkg::LVL_IO_DATA] = data_any; // see R02 R06
      set_req[interrupt_pkg::LVL_IO_SERVICE] = service_any; // see R02 R06
      set_req[interrupt_pkg::LVL_POWER_FAIL] = ext_request_in[0] | power_fail_autostart_in; // see R06
      set_req[interrupt_pkg::LVL_PARITY] = ext_request_in[1] | parity_trap_in; // see R20
      set_req[interrupt_pkg::LVL_PROTECT] = ext_request_in[2] | protect_trap_in; // see R20
      set_req[interrupt_pkg::LVL_UNIMPL] = ext_request_in[4] | unimpl_trap_in; // see R06 R20
      set_req[interrupt_pkg::LVL_FP_OVERFLOW] = ext_request_in[5] | fp_overflow_trap_in; // see R20
      clr_req = 32'h0000_0000;
      set_en = 32'h0000_0000;
      clr_en = 32'h0000_0000;
      set_act = 32'h0000_0000;
      clr_act = 32'h0000_0000;
      if (instr_here) begin
         unique case (instr_op_in)
            interrupt_pkg::SET_REQUEST_INSTR: set_req = set_req | instr_sel; // see R07
            interrupt_pkg::CLEAR_REQUEST_INSTR: clr_req = instr_sel; // see R07
            interrupt_pkg::SET_ENABLE_INSTR: set_en = instr_sel; // see R08 R22 R24
            interrupt_pkg::CLEAR_ENABLE_INSTR: clr_en = instr_sel; // see R08 R22 R24
            interrupt_pkg::SET_ACTIVE_INSTR: set_act = instr_sel & 32'hFFFF_FFFE; // see R11
            interrupt_pkg::CLEAR_ACTIVE_INSTR: clr_act = instr_sel; // see R11
            interrupt_pkg::EXECUTIVE_SERVICE_INSTR:
               set_req[interrupt_pkg::LVL_UNIMPL] = 1'b1; // see R21
            default: ;
         endcase
      end
      if (start_return && highest_active[5]) begin
         clr_act = level_onehot(highest_active[4:0]); // see R09 R15
         if (instr_op_in == interrupt_pkg::CLEAR_AND_RETURN_INSTR) begin
            clr_req = level_onehot(highest_active[4:0]); // see R07 R15
         end
      end
      if (start_take) begin
         set_act = set_act | level_onehot(take[4:0]); // see R09
      end
   end
   always_comb begin
      if (level_sel == interrupt_pkg::LVL_IO_DATA) begin
         entry_addr = interrupt_pkg::DATA_ENTRY_BASE | {10'h000, device_id_in}; // see R04 R17
      end else if (level_sel == interrupt_pkg::LVL_IO_SERVICE) begin
         entry_addr = interrupt_pkg::SERVICE_ENTRY_BASE | {10'h000, device_id_in}; // see R19
      end else begin
         entry_addr = interrupt_pkg::entry_word(level_sel); // see R03
      end
   end
   always_comb begin
      next_state = state;
      next_level_sel = level_sel;
      next_reenter = reenter;
      next_cnt = cnt + interrupt_pkg::SWITCH_CNT_W'(1);
      next_mem_req = mem_req_out;
      next_mem_write = mem_write_out;
      next_mem_addr = mem_addr_out;
      next_mem_wdata = mem_wdata_out;
      next_pc_load = 1'b0;
      next_pc_value = pc_value_out;
      sub_release = 1'b0;
      unique case (state)
         ST_IDLE, ST_RECHECK: begin
            next_state = ST_IDLE;
            if (start_return) begin
               next_reenter = instr_op_in == interrupt_pkg::CLEAR_AND_RETURN_INSTR; // see R18
               next_mem_req = 1'b1;
               next_mem_write = 1'b0;
               next_mem_addr = highest_active[5] ?
                               interrupt_pkg::return_word(highest_active[4:0]) :
                               interrupt_pkg::NO_ACTIVE_RETURN_ADDR; // see R15 R23
               next_state = ST_RET_FETCH;
            end else if (start_take) begin
               next_level_sel = take[4:0];
               next_cnt = interrupt_pkg::SWITCH_CNT_W'(1);
               next_mem_req = 1'b1;
               next_mem_write = 1'b1;
               next_mem_addr = interrupt_pkg::return_word(take[4:0]); // see R04 R14 R17
               next_mem_wdata = program_counter_in; // see R14
               next_state = ST_SAVE;
            end
         end
         ST_SAVE: begin
            if (mem_ack_in) begin
               next_mem_write = 1'b0;
               next_mem_addr = entry_addr; // see R14
               next_state = ST_FETCH;
            end
         end
         ST_FETCH: begin
            if (mem_ack_in) begin
               next_mem_req = 1'b0;
               next_pc_value = mem_rdata_in;
               next_state = ST_PAD;
            end
         end
         ST_PAD: begin
            // Fast memory still costs the full switch time seen by the CPU.
            if (cnt >= interrupt_pkg::SWITCH_CNT_W'(interrupt_pkg::SWITCH_CYCLES - 1)) begin
               next_pc_load = 1'b1; // see R14
               sub_release = 1'b1;
               next_state = ST_IDLE;
            end
         end
         ST_RET_FETCH: begin
            if (mem_ack_in) begin
               next_mem_req = 1'b0;
               next_pc_value = mem_rdata_in; // see R15 R23
               next_pc_load = 1'b1;
               // After clear-active-and-return a pending level waits one instruction.
               next_state = reenter ? ST_RECHECK : ST_IDLE; // see R10 R18
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         state <= ST_IDLE;
         level_sel <= 5'h00;
         reenter <= 1'b0;
         cnt <= '0;
         mem_req_out <= 1'b0;
         mem_write_out <= 1'b0;
         mem_addr_out <= 16'h0000;
         mem_wdata_out <= 16'h0000;
         pc_load_out <= 1'b0;
         pc_value_out <= 16'h0000;
      end else begin
         state <= next_state;
         level_sel <= next_level_sel;
         reenter <= next_reenter;
         cnt <= next_cnt;
         mem_req_out <= next_mem_req;
         mem_write_out <= next_mem_write;
         mem_addr_out <= next_mem_addr;
         mem_wdata_out <= next_mem_wdata;
         pc_load_out <= next_pc_load;
         pc_value_out <= next_pc_value;
      end
   end

   assign busy_out = state != ST_IDLE;

endmodule
`default_nettype wire

// *** verification/priority_interrupt_system_monitor.sv ***
// Port checker for the priority interrupt controller.
`timescale 1ns/100ps
`default_nettype none
module priority_interrupt_system_monitor (
   input wire logic        clock_in,
   input wire logic        srst_in,
   input wire logic        instr_valid_in,
   input wire logic [3:0]  instr_op_in,
   input wire logic [4:0]  instr_level_in,
   input wire logic        unimpl_trap_in,
   input wire logic        mem_ack_in,
   input wire logic        mem_req_out,
   input wire logic        mem_write_out,
   input wire logic [15:0] mem_addr_out,
   input wire logic        pc_load_out,
   input wire logic        busy_out,
   input wire logic        abort_instr_out,
   input wire logic        pc_hold_out,
   input wire logic [31:0] request_out,
   input wire logic [31:0] enable_out,
   input wire logic [31:0] active_out
);
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (srst_in);
   logic go;
   assign go = instr_valid_in && !busy_out;
   sequence s_save;
      mem_req_out && mem_write_out && mem_ack_in;
   endsequence
   sequence s_fetch;
      mem_req_out && !mem_write_out;
   endsequence
   property p_reset;
      $fell(srst_in) |-> !request_out && !active_out && enable_out == 32'h0000_0037;
   endproperty
   a_reset: assert property (p_reset) else $error("state after reset");
   property p_en_set;
      go && instr_op_in == 4'h3 && instr_level_in == 5'h07 |=> enable_out[7];
   endproperty
   a_en_set: assert property (p_en_set) else $error("enable not set");
   property p_fixed_en;
      enable_out[5:4] == 2'b11 && enable_out[2:0] == 3'b111;
   endproperty
   a_fixed_en: assert property (p_fixed_en) else $error("fixed enable lost");
   property p_trap;
      unimpl_trap_in |-> abort_instr_out && pc_hold_out;
   endproperty
   a_trap: assert property (p_trap) else $error("trap not honoured");
   property p_save_read;
      s_save |=> s_fetch;
   endproperty
   a_save_read: assert property (p_save_read) else $error("no entry fetch");
   property p_switch_time;
      $rose(mem_req_out) && mem_write_out |-> ##[239:300] pc_load_out;
   endproperty
   a_switch_time: assert property (p_switch_time) else $error("switch time");
   property p_no_active;
      go && instr_op_in == 4'h7 && !active_out |=> s_fetch and mem_addr_out == 16'h0000;
   endproperty
   a_no_active: assert property (p_no_active) else $error("idle return");
   property p_car;
      go && instr_op_in == 4'h8 && active_out == 32'h0000_0080 && request_out[7]
         |=> request_out[7] && !active_out;
   endproperty
   a_car: assert property (p_car) else $error("active return");
   property p_cir;
      go && instr_op_in == 4'h7 && active_out == 32'h0000_0080
         |=> !request_out[7] && !active_out;
   endproperty
   a_cir: assert property (p_cir) else $error("clear return");
endmodule
bind priority_interrupt_system priority_interrupt_system_monitor
   u_priority_interrupt_system_monitor (.*);
`default_nettype wire

// *** verification/interrupt_memory_model.sv ***
// Memory holding the dedicated words, answering promptly or slowly.
`timescale 1ns/100ps
`default_nettype none
module interrupt_memory_model (
   input  wire logic        clock_in,
   input  wire logic        slow_in,
   input  wire logic        mem_req_out,
   input  wire logic        mem_write_out,
   input  wire logic [15:0] mem_addr_out,
   input  wire logic [15:0] mem_wdata_out,
   output logic             mem_ack_in,
   output logic [15:0]      mem_rdata_in
);
   logic [15:0] mem [256];
   int          wait_cnt = 0;
   initial begin
      mem_ack_in = 1'b0;
      mem_rdata_in = 16'h0000;
      for (int i = 0; i < 256; i++) begin
         mem[i] = 16'hC000 ^ 16'(i);
      end
   end
   always @(posedge clock_in) begin
      mem_ack_in <= 1'b0;
      mem_rdata_in <= ~mem_rdata_in;
      if (mem_req_out && !mem_ack_in && wait_cnt >= (slow_in ? 3 : 0)) begin
         mem_ack_in <= 1'b1;
         wait_cnt <= 0;
         mem_rdata_in <= mem[mem_addr_out[7:0]];
         if (mem_write_out) begin
            mem[mem_addr_out[7:0]] <= mem_wdata_out;
         end
      end else if (mem_req_out) begin
         wait_cnt <= wait_cnt + 1;
      end
   end
endmodule
`default_nettype wire

// *** verification/priority_interrupt_system_test.sv ***
// Self-checking bench for the priority interrupt controller.
`timescale 1ns/100ps
`default_nettype none
module priority_interrupt_system_test;
   logic        clock_in = 1'b0, srst_in = 1'b1, slow_in = 1'b0, instr_done_in = 1'b0;
   logic        power_fail_autostart_in = 1'b0, instr_valid_in = 1'b0;
   logic        unimpl_trap_in = 1'b0, parity_trap_in = 1'b0;
   logic        protect_trap_in = 1'b0, fp_overflow_trap_in = 1'b0;
   logic [31:0] ext_request_in = 32'h0000_0000;
   logic [16:0] data_sub_request_in = 17'h0_0000, service_sub_request_in = 17'h0_0000;
   logic [5:0]  device_id_in = 6'h03;
   logic [3:0]  instr_op_in = 4'h0;
   logic [4:0]  instr_level_in = 5'h00;
   logic [15:0] program_counter_in = 16'h1234;
   logic [15:0] mem_rdata_in, mem_addr_out, mem_wdata_out, pc_value_out;
   logic        mem_ack_in, mem_req_out, mem_write_out, pc_load_out, busy_out;
   logic        abort_instr_out, pc_hold_out;
   logic [16:0] data_sub_ack_out, service_sub_ack_out;
   logic [31:0] request_out, enable_out, active_out;
   int          mismatches = 0, tests_run = 0, cycles = 0;
   priority_interrupt_system u_priority_interrupt_system (.*);
   interrupt_memory_model u_interrupt_memory_model (.*);
   always #5 clock_in = ~clock_in;
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   always @(posedge clock_in) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         finish_test();
      end
   end
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic op(input logic [3:0] c, input logic [4:0] l);
      for (int n = 0; n < 600 && busy_out !== 1'b0; n++) begin
         @(negedge clock_in);
      end
      instr_op_in = c;
      instr_level_in = l;
      instr_valid_in = 1'b1;
      @(negedge clock_in);
      instr_valid_in = 1'b0;
      @(negedge clock_in);
   endtask
   task automatic wpc(input logic [15:0] exp);
      for (int n = 0; n < 400 && pc_load_out !== 1'b1; n++) begin
         @(posedge clock_in);
         #1;
      end
      chk("pc", pc_value_out, exp);
      repeat (2) @(negedge clock_in);
   endtask
   initial begin
      repeat (2) @(negedge clock_in);
      srst_in = 1'b0;
      chk("enables", enable_out, 32'h0000_0037);
      chk("latches", request_out | active_out, 32'h0000_0000);
      ext_request_in = 32'h0000_0080;
      @(negedge clock_in);
      ext_request_in = 32'h0000_0000;
      op(4'h3, 5'h07);
      chk("request", request_out, 32'h0000_0080);
      repeat (4) @(negedge clock_in);
      chk("idle", busy_out, 1'b0);
      instr_done_in = 1'b1;
      wpc(16'hC02F);
      chk("active", active_out, 32'h0000_0080);
      chk("return word", u_interrupt_memory_model.mem[8'h2E], 16'h1234);
      instr_done_in = 1'b0;
      op(4'h7, 5'h00);
      wpc(16'h1234);
      op(4'h1, 5'h07);
      op(4'h5, 5'h07);
      chk("set active", active_out, 32'h0000_0080);
      instr_done_in = 1'b1;
      repeat (4) @(negedge clock_in);
      chk("deferred", busy_out, 1'b0);
      instr_done_in = 1'b0;
      op(4'h8, 5'h00);
      wpc(16'h1234);
      chk("kept", request_out | active_out, 32'h0000_0080);
      op(4'h2, 5'h07);
      op(4'h7, 5'h00);
      wpc(16'hC000);
      op(4'h4, 5'h07);
      op(4'h4, 5'h04);
      chk("enables", enable_out, 32'h0000_0037);
      slow_in = 1'b1;
      op(4'h3, 5'h0C);
      op(4'h3, 5'h0D);
      data_sub_request_in = 17'h0_0028;
      service_sub_request_in = 17'h0_0001;
      instr_done_in = 1'b1;
      repeat (8) @(negedge clock_in);
      chk("data grant", data_sub_ack_out, 17'h0_0008);
      chk("service grant", service_sub_ack_out, 17'h0_0000);
      wpc(16'hC083);
      chk("data return", u_interrupt_memory_model.mem[8'h38], 16'h1234);
      instr_done_in = 1'b0;
      data_sub_request_in = 17'h0_0020;
      device_id_in = 6'h05;
      op(4'h7, 5'h00);
      wpc(16'h1234);
      wpc(16'hC085);
      data_sub_request_in = 17'h0_0000;
      op(4'h7, 5'h00);
      wpc(16'h1234);
      wpc(16'hC0C5);
      service_sub_request_in = 17'h0_0000;
      data_sub_request_in = 17'h0_0001;
      instr_done_in = 1'b1;
      wpc(16'hC085);
      instr_done_in = 1'b0;
      data_sub_request_in = 17'h0_0000;
      op(4'h6, 5'h0C);
      op(4'h6, 5'h0D);
      chk("actives", active_out, 32'h0000_0000);
      for (int i = 0; i < 4; i++) begin
         {fp_overflow_trap_in, protect_trap_in, parity_trap_in, unimpl_trap_in} = 4'(1 << i);
         #1;
         chk("abort", abort_instr_out, 1'b1);
         chk("hold", pc_hold_out, unimpl_trap_in);
         @(negedge clock_in);
      end
      {fp_overflow_trap_in, protect_trap_in, parity_trap_in} = 3'h0;
      power_fail_autostart_in = 1'b1;
      @(negedge clock_in);
      power_fail_autostart_in = 1'b0;
      chk("trap requests", request_out[5:0], 6'h37);
      op(4'h2, 5'h04);
      op(4'h9, 5'h00);
      chk("service request", request_out[4], 1'b1);
      finish_test();
   end
endmodule
`default_nettype wire
